// ==== common/dmcp_pkg.sv ====
// dmcp_pkg: constants and state types for the dual-mode control port.
// assumes a single 250 MHz system clock; bus pins arrive asynchronously.
`default_nettype none

package dmcp_pkg;

	// ==========================================================
	// i2c framing
	localparam logic [7:0] I2C_BASE_ADDR = 8'h90;
	localparam logic [7:0] I2C_TOP_ADDR = 8'h9E;
	localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
	localparam logic [3:0] I2C_ACK_BIT = 4'h9;

	// ==========================================================
	// spi framing: direction bit, 15 address bits, 16 padding bits
	localparam logic [5:0] SPI_ADDR_END = 6'h10;
	localparam logic [5:0] SPI_PAD_END = 6'h20;
	localparam logic [3:0] SPI_WORD_LAST = 4'hF;

	// ==========================================================
	// shared values
	localparam logic [15:0] REG_ADDR_STEP = 16'h0002;
	localparam logic [15:0] REG_ADDR_RST = 16'h0000;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam int SYNC_W = 8;
	// idle pin levels (sck low), so no false edge follows reset
	localparam logic [SYNC_W-1:0] SYNC_INIT = 8'hFD;

	typedef enum logic [2:0] {
		I_IDLE,
		I_DEV,
		I_ADDH,
		I_ADDL,
		I_WRH,
		I_WRL,
		I_READ,
		I_SKIP
	} dmcp_i2c_st_t;

endpackage

`default_nettype wire

// ==== rtl/dmcp_sync.sv ====
// dmcp_sync: two-flop synchronisers plus one history stage per bit.
// assumes each input is a slow pin level; q_d is q one clock earlier.
`default_nettype none

module dmcp_sync
	import dmcp_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [SYNC_W-1:0] d,
	output logic [SYNC_W-1:0] q,
	output logic [SYNC_W-1:0] q_d
);

	logic [SYNC_W-1:0] meta_r;

	// ==========================================================
	// per-bit chain; the first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_bit
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					meta_r[gi] <= SYNC_INIT[gi];
					q[gi] <= SYNC_INIT[gi];
					q_d[gi] <= SYNC_INIT[gi];
				end else begin
					meta_r[gi] <= d[gi];
					q[gi] <= meta_r[gi];
					q_d[gi] <= q[gi];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ==== rtl/dmcp_top.sv ====
// dmcp_top: i2c target / spi peripheral control port for 16-bit registers.
// assumes the register file answers reg_rd with reg_rdata one clock later.
//
// Function
// - lock to first valid i2c or spi activity
// - sda only pulled low, never driven high
// - device address byte: lsb is direction
// - strap selects write address 0x90 to 0x9E
// - shift in eight address bits msb first
// - acknowledge matching address by pulling sda low
// - mismatch or bad direction returns to idle
// - stop condition ends transfer, back to idle
// - stray start or stop mid-byte aborts transfer
// - 16-bit register address then 16-bit words
// - single and auto-increment multiple transfers
// - spi read ignores sdi after address
// - sdo driven only while reading under chip select
// - sdo bit valid at sck rising edge
// - frame: direction, address, padding, data words
// - words continue every sixteen sck cycles
// - spi burst address advances by two
`default_nettype none

module dmcp_top
	import dmcp_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] address_strap_pin,
	input wire logic i2c_scl_in,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_sdi,
	output logic spi_sdo_out,
	output logic spi_sdo_oe,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata,
	output logic mode_i2c,
	output logic mode_spi
);

	// ==========================================================
	// pin synchronisers and edge decode
	logic [SYNC_W-1:0] s;
	logic [SYNC_W-1:0] sp;

	dmcp_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.d({address_strap_pin, i2c_scl_in, i2c_sda_in, spi_cs_n, spi_sck, spi_sdi}),
		.q(s),
		.q_d(sp)
	);

	wire logic [2:0] strap = s[7:5];
	wire logic scl = s[4];
	wire logic sda = s[3];
	wire logic cs_n = s[2];
	wire logic sdi = s[0];
	wire logic scl_rise = s[4] & ~sp[4];
	wire logic scl_fall = ~s[4] & sp[4];
	wire logic sck_rise = s[1] & ~sp[1];
	wire logic sck_fall = ~s[1] & sp[1];
	// sda moving while scl stays high marks start or stop
	wire logic start_c = scl & sp[4] & ~sda & sp[3];
	wire logic stop_c = scl & sp[4] & sda & ~sp[3];

	// ==========================================================
	// mode lock and strap capture
	logic mode_i2c_r;
	logic mode_spi_r;
	logic strap_ok_r;
	logic [1:0] strap_cnt_r;
	logic [7:0] own_r;

	wire logic i2c_ok = ~mode_spi_r & strap_ok_r;
	wire logic spi_ok = ~mode_i2c_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_i2c_r <= 1'b0;
			mode_spi_r <= 1'b0;
		end else if (!mode_i2c_r && !mode_spi_r) begin
			// whichever bus shows a valid event first wins for good
			mode_i2c_r <= start_c & strap_ok_r;
			mode_spi_r <= ~(start_c & strap_ok_r) & ~cs_n & sck_rise;
		end
	end

	// strap is a level: sampled after release, once the synchroniser has settled
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_cnt_r <= 2'h0;
			strap_ok_r <= 1'b0;
			own_r <= I2C_BASE_ADDR;
		end else if (!strap_ok_r) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == STRAP_SETTLE) begin
				own_r <= I2C_BASE_ADDR + {4'h0, strap, 1'b0};
				strap_ok_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// i2c target engine
	dmcp_i2c_st_t st_r;
	logic [3:0] cnt_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic oe_r;
	logic rd_r;
	logic mack_r;
	logic hl_r;
	logic aok_r;
	logic [15:0] ia_r;
	logic [7:0] wh_r;
	logic iwr_r;
	logic ird_r;
	logic [15:0] ireq_a_r;
	logic [15:0] ireq_d_r;
	logic [15:0] rw_r;

	// top seven bits compare; bit 0 is the direction flag
	wire logic dev_match = (rx_r[7:1] == own_r[7:1]);
	wire logic byte_done = scl_fall & (cnt_r == I2C_BYTE_BITS);
	wire logic ack_done = scl_fall & (cnt_r == I2C_ACK_BIT);
	wire logic [7:0] nxt_byte = hl_r ? rw_r[7:0] : rw_r[15:8];
	wire logic [15:0] ia_nxt = ia_r + REG_ADDR_STEP;
	wire logic [2:0] tx_idx = 3'(4'h7 - cnt_r);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= I_IDLE;
			cnt_r <= 4'h0;
			rx_r <= 8'h00;
			tx_r <= 8'h00;
			oe_r <= 1'b0;
			rd_r <= 1'b0;
			mack_r <= 1'b0;
			hl_r <= 1'b0;
			aok_r <= 1'b0;
			ia_r <= REG_ADDR_RST;
			wh_r <= 8'h00;
			iwr_r <= 1'b0;
			ird_r <= 1'b0;
			ireq_a_r <= REG_ADDR_RST;
			ireq_d_r <= 16'h0000;
		end else begin
			iwr_r <= 1'b0;
			ird_r <= 1'b0;
			if (stop_c && i2c_ok) begin
				st_r <= I_IDLE;
				oe_r <= 1'b0;
				rd_r <= 1'b0;
				cnt_r <= 4'h0;
			end else if (start_c && i2c_ok) begin
				// a repeated start follows the first bit's scl rise, so it sees a count of one
				st_r <= (st_r == I_IDLE || cnt_r <= 4'h1) ? I_DEV : I_IDLE;
				aok_r <= aok_r & (st_r != I_IDLE);
				cnt_r <= 4'h0;
				oe_r <= 1'b0;
				rd_r <= 1'b0;
			end else if (st_r == I_IDLE || st_r == I_SKIP) begin
				cnt_r <= 4'h0;
			end else if (scl_rise) begin
				if (cnt_r < I2C_BYTE_BITS) begin
					rx_r <= {rx_r[6:0], sda};
				end else if (rd_r) begin
					mack_r <= ~sda;
				end
				if (cnt_r < I2C_ACK_BIT) begin
					cnt_r <= cnt_r + 4'h1;
				end
			end else if (byte_done) begin
				// receiving: pull low for ack; sending: let go for controller ack
				oe_r <= ~rd_r;
				case (st_r)
					I_DEV: begin
						if (!dev_match || (rx_r[0] && !aok_r)) begin
							oe_r <= 1'b0;
							st_r <= I_IDLE;
						end else if (rx_r[0]) begin
							rd_r <= 1'b1;
							hl_r <= 1'b0;
							ird_r <= 1'b1;
							ireq_a_r <= ia_r;
							st_r <= I_READ;
						end else begin
							st_r <= I_ADDH;
						end
					end
					I_ADDH: begin
						ia_r[15:8] <= rx_r;
						st_r <= I_ADDL;
					end
					I_ADDL: begin
						ia_r[7:0] <= rx_r;
						aok_r <= 1'b1;
						st_r <= I_WRH;
					end
					I_WRH: begin
						wh_r <= rx_r;
						st_r <= I_WRL;
					end
					I_WRL: begin
						iwr_r <= 1'b1;
						ireq_a_r <= ia_r;
						ireq_d_r <= {wh_r, rx_r};
						ia_r <= ia_nxt;
						st_r <= I_WRH;
					end
					I_READ: begin
						if (!hl_r) begin
							// low byte just sent: fetch the following word early
							ird_r <= 1'b1;
							ireq_a_r <= ia_nxt;
							ia_r <= ia_nxt;
						end
					end
					default: begin
						st_r <= I_IDLE;
					end
				endcase
			end else if (ack_done) begin
				cnt_r <= 4'h0;
				oe_r <= 1'b0;
				if (rd_r && !mack_r) begin
					st_r <= I_SKIP;
				end else if (rd_r) begin
					tx_r <= nxt_byte;
					oe_r <= ~nxt_byte[7];
					hl_r <= ~hl_r;
				end
			end else if (scl_fall && rd_r && cnt_r != 4'h0 && cnt_r < I2C_BYTE_BITS) begin
				oe_r <= ~tx_r[tx_idx];
			end
		end
	end

	// ==========================================================
	// spi peripheral engine
	logic [5:0] sc_r;
	logic [3:0] dc_r;
	logic srw_r;
	logic [15:0] sa_r;
	logic [15:0] sd_r;
	logic [15:0] sh_r;
	logic sdo_r;
	logic soe_r;
	logic swr_r;
	logic srd_r;
	logic [15:0] sreq_a_r;
	logic [15:0] sreq_d_r;

	wire logic [15:0] addr_in = {1'b0, sa_r[13:0], sdi};
	wire logic [15:0] sa_nxt = sa_r + REG_ADDR_STEP;
	wire logic in_data = (sc_r == SPI_PAD_END);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sc_r <= 6'h00;
			dc_r <= 4'h0;
			srw_r <= 1'b0;
			sa_r <= REG_ADDR_RST;
			sd_r <= 16'h0000;
			sh_r <= 16'h0000;
			sdo_r <= 1'b0;
			soe_r <= 1'b0;
			swr_r <= 1'b0;
			srd_r <= 1'b0;
			sreq_a_r <= REG_ADDR_RST;
			sreq_d_r <= 16'h0000;
		end else begin
			swr_r <= 1'b0;
			srd_r <= 1'b0;
			if (cs_n || !spi_ok) begin
				sc_r <= 6'h00;
				dc_r <= 4'h0;
				soe_r <= 1'b0;
				sdo_r <= 1'b0;
			end else if (sck_rise && !in_data) begin
				sc_r <= sc_r + 6'h01;
				if (sc_r == 6'h00) begin
					srw_r <= sdi;
				end else if (sc_r < SPI_ADDR_END) begin
					sa_r <= addr_in;
				end
				if (sc_r == SPI_ADDR_END - 6'h01 && srw_r) begin
					srd_r <= 1'b1;
					sreq_a_r <= addr_in;
				end
			end else if (sck_rise) begin
				dc_r <= dc_r + 4'h1;
				if (!srw_r) begin
					sd_r <= {sd_r[14:0], sdi};
				end
				if (dc_r == SPI_WORD_LAST) begin
					sa_r <= sa_nxt;
					if (!srw_r) begin
						swr_r <= 1'b1;
						sreq_a_r <= sa_r;
						sreq_d_r <= {sd_r[14:0], sdi};
					end else begin
						srd_r <= 1'b1;
						sreq_a_r <= sa_nxt;
					end
				end
			end else if (sck_fall && in_data && srw_r) begin
				// change on the falling edge so the bit is stable at the next rise
				soe_r <= 1'b1;
				if (dc_r == 4'h0) begin
					sdo_r <= rw_r[15];
					sh_r <= {rw_r[14:0], 1'b0};
				end else begin
					sdo_r <= sh_r[15];
					sh_r <= {sh_r[14:0], 1'b0};
				end
			end
		end
	end

	// ==========================================================
	// register-side port; only one engine is ever active
	logic rd_q_r;
	logic reg_wr_r;
	logic reg_rd_r;
	logic [15:0] reg_addr_r;
	logic [15:0] reg_wdata_r;

	wire logic i_req = iwr_r | ird_r;
	wire logic s_req = swr_r | srd_r;
	wire logic [15:0] addr_sel = i_req ? ireq_a_r : sreq_a_r;
	wire logic [15:0] data_sel = i_req ? ireq_d_r : sreq_d_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_wr_r <= 1'b0;
			reg_rd_r <= 1'b0;
			rd_q_r <= 1'b0;
			reg_addr_r <= REG_ADDR_RST;
			reg_wdata_r <= 16'h0000;
			rw_r <= 16'h0000;
		end else begin
			reg_wr_r <= iwr_r | swr_r;
			reg_rd_r <= ird_r | srd_r;
			rd_q_r <= reg_rd_r;
			if (i_req || s_req) begin
				reg_addr_r <= addr_sel;
				reg_wdata_r <= data_sel;
			end
			if (rd_q_r) begin
				rw_r <= reg_rdata;
			end
		end
	end

	assign reg_wr = reg_wr_r;
	assign reg_rd = reg_rd_r;
	assign reg_addr = reg_addr_r;
	assign reg_wdata = reg_wdata_r;
	assign i2c_sda_oe = oe_r;
	assign i2c_sda_out = 1'b0;
	assign spi_sdo_out = sdo_r;
	assign spi_sdo_oe = soe_r;
	assign mode_i2c = mode_i2c_r;
	assign mode_spi = mode_spi_r;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_dev_write_hit;
		byte_done && st_r == I_DEV && dev_match && !rx_r[0];
	endsequence

	sequence s_bus_stop;
		stop_c && i2c_ok;
	endsequence

	a_mode_sticky: assert property (
		(mode_i2c_r || mode_spi_r) |=> $stable({mode_i2c_r, mode_spi_r}) && !(mode_i2c_r && mode_spi_r))
		else $error("control port mode changed after lock");
	a_sda_low_only: assert property (
		i2c_sda_oe |-> mode_i2c_r && i2c_sda_out == 1'b0)
		else $error("sda driven outside i2c mode or driven high");
	a_own_address: assert property (
		$rose(strap_ok_r) |-> own_r >= I2C_BASE_ADDR && own_r <= I2C_TOP_ADDR && !own_r[0])
		else $error("strapped address out of range");
	a_addr_ack: assert property (
		s_dev_write_hit |=> (i2c_sda_oe && st_r == I_ADDH) [*2])
		else $error("matching address not acknowledged");
	a_nomatch_idle: assert property (
		byte_done && st_r == I_DEV && !dev_match |=> st_r == I_IDLE && !i2c_sda_oe)
		else $error("mismatched address not dropped");
	a_stop_idle: assert property (
		s_bus_stop |=> st_r == I_IDLE && !i2c_sda_oe)
		else $error("stop did not return to idle");
	a_midbyte_abort: assert property (
		start_c && i2c_ok && st_r != I_IDLE && cnt_r > 4'h1 |=> st_r == I_IDLE)
		else $error("stray start mid-byte not aborted");
	a_i2c_autoinc: assert property (
		iwr_r |-> ia_r == ireq_a_r + REG_ADDR_STEP)
		else $error("i2c address not advanced after write");
	a_sdi_ignored: assert property (
		srw_r && in_data && !cs_n |=> $stable(sd_r))
		else $error("sdi sampled during spi read data");
	a_sdo_released: assert property (
		cs_n |=> !spi_sdo_oe)
		else $error("sdo driven with chip select high");
	a_sdo_on_fall: assert property (
		$changed(spi_sdo_out) && spi_sdo_oe |-> $past(sck_fall))
		else $error("sdo changed away from sck falling edge");
	a_spi_wr_word: assert property (
		sck_rise && in_data && !cs_n && spi_ok && !srw_r && dc_r == SPI_WORD_LAST |=> swr_r)
		else $error("spi word not written after sixteen bits");
	a_spi_step: assert property (
		swr_r |-> sa_r == sreq_a_r + REG_ADDR_STEP)
		else $error("spi burst address not advanced by two");

endmodule

`default_nettype wire

// ==== tb/dmcp_host.sv ====
// dmcp_host: bus controller model for the i2c and spi sides of the port.
// assumes the bench resolves sda from both pull-downs and floats sdo when released.
`default_nettype none

module dmcp_host (
	input wire logic clk,
	output logic scl,
	output logic sda_low,
	input wire logic sda,
	output logic cs_n,
	output logic sck,
	output logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// ==========================================================
	// i2c: scl half period of 20 clocks, sda moves mid-low
	task automatic start;
		sda_low = 1'b0;
		tick(10);
		scl = 1'b1;
		tick(20);
		sda_low = 1'b1;
		tick(20);
		scl = 1'b0;
	endtask

	task automatic stop;
		tick(10);
		sda_low = 1'b1;
		tick(10);
		scl = 1'b1;
		tick(20);
		sda_low = 1'b0;
		tick(20);
	endtask

	// n bits from o[8] down, sampled at the end of scl high
	task automatic xfer(input logic [8:0] o, input int n, output logic [8:0] i);
		i = '1;
		for (int k = 8; k > 8 - n; k--) begin
			tick(10);
			sda_low = ~o[k];
			tick(10);
			scl = 1'b1;
			tick(20);
			i[k] = sda;
			scl = 1'b0;
		end
	endtask

	task automatic tx(input logic [7:0] b, output logic ack);
		logic [8:0] i;
		xfer({b, 1'b1}, 9, i);
		ack = (i[0] === 1'b0);
	endtask

	task automatic rx(input logic last, output logic [7:0] d);
		logic [8:0] i;
		xfer({8'hFF, last}, 9, i);
		d = i[8:1];
	endtask

	// ==========================================================
	// spi mode 0: sck stands low outside frames
	task automatic spi_begin;
		cs_n = 1'b0;
		tick(10);
	endtask

	task automatic spi_end;
		tick(10);
		cs_n = 1'b1;
		sdi = ~sdi;
		tick(10);
	endtask

	task automatic word(input logic [15:0] o, output logic [15:0] i);
		for (int k = 15; k >= 0; k--) begin
			sdi = o[k];
			tick(10);
			i[k] = sdo;
			sck = 1'b1;
			tick(10);
			sck = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// ==== tb/test_dual_mode_control_port.sv ====
// test_dual_mode_control_port: self-checking bench for dmcp_top.
// assumes dmcp_host drives the bus; the bench holds a register file model.
`default_nettype none

module test_dual_mode_control_port
	import dmcp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] strap = 3'h0;
	logic [7:0] dev_w;
	logic scl, sda_low, cs_n, sck, sdi;
	logic sda_oe, sda_out, sdo_out, sdo_oe, reg_wr, reg_rd, mode_i2c, mode_spi;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic sda, sdo_w;
	logic [31:0] wq[$];
	logic [31:0] eq[$];
	int n_errors = 0;
	int n_compared = 0;

	always #2 clk = ~clk;
	assign sda = (sda_low | sda_oe) ? 1'b0 : 1'b1;
	assign sdo_w = sdo_oe ? sdo_out : 1'bz;

	dmcp_top DUT (.clk(clk), .rstn(rstn), .address_strap_pin(strap),
		.i2c_scl_in(scl), .i2c_sda_in(sda), .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe),
		.spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi), .spi_sdo_out(sdo_out),
		.spi_sdo_oe(sdo_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_i2c(mode_i2c), .mode_spi(mode_spi));

	dmcp_host host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda), .cs_n(cs_n),
		.sck(sck), .sdi(sdi), .sdo(sdo_w));

	function automatic logic [15:0] rf(input logic [15:0] a);
		return {a[7:0], a[15:8]} ^ 16'h5A3C;
	endfunction

	// ==========================================================
	// register file: data one clock after reg_rd, noise otherwise
	always @(posedge clk) begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= reg_rd ? rf(reg_addr) : ~reg_rdata;
		if (reg_wr)
			wq.push_back({reg_addr, reg_wdata});
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic drain;
		chk("write count", 32'(wq.size()), 32'(eq.size()));
		while (wq.size() > 0 && eq.size() > 0)
			chk("write", wq.pop_front(), eq.pop_front());
		wq.delete();
		eq.delete();
	endtask

	task automatic do_reset;
		rstn = 1'b0;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		repeat (20) @(negedge clk);
	endtask

	// ==========================================================
	// i2c transfers
	task automatic i2c_op(input logic rd, input logic [15:0] a, input int n);
		logic ack;
		logic [7:0] h, l;
		logic [15:0] d, ra;
		host.start();
		host.tx(dev_w, ack);
		chk("dev ack", ack, 1'b1);
		host.tx(a[15:8], ack);
		host.tx(a[7:0], ack);
		chk("addr ack", ack, 1'b1);
		if (rd) begin
			host.start();
			host.tx(dev_w | 8'h01, ack);
			chk("read ack", ack, 1'b1);
		end
		for (int k = 0; k < n; k++) begin
			d = 16'($urandom);
			ra = a + 16'(k) * REG_ADDR_STEP;
			if (rd) begin
				host.rx(1'b0, h);
				host.rx(k == n - 1, l);
				chk("i2c read", {h, l}, rf(ra));
			end else begin
				host.tx(d[15:8], ack);
				host.tx(d[7:0], ack);
				chk("data ack", ack, 1'b1);
				eq.push_back({ra, d});
			end
		end
		host.stop();
		drain();
	endtask

	task automatic i2c_refuse(input logic [7:0] dev);
		logic ack;
		host.start();
		host.tx(dev, ack);
		chk("refused ack", ack, 1'b0);
		host.tx(8'h12, ack);
		chk("ignored ack", ack, 1'b0);
		host.stop();
		drain();
	endtask

	// ==========================================================
	// spi frames; live low means the port must ignore the frame
	task automatic spi_op(input logic rd, input logic [14:0] a, input int n, input logic live);
		logic [15:0] d, s, ra;
		host.spi_begin();
		host.word({rd, a}, s);
		host.word(16'h0000, s);
		chk("sdo header", s, 16'hZZZZ);
		for (int k = 0; k < n; k++) begin
			d = 16'($urandom);
			ra = {1'b0, a} + 16'(k) * REG_ADDR_STEP;
			host.word(d, s);
			if (rd && live)
				chk("spi read", s, rf(ra));
			else if (live)
				eq.push_back({ra, d});
		end
		host.spi_end();
		chk("sdo release", sdo_oe, 1'b0);
		drain();
	endtask

	initial begin
		logic [2:0] c;
		logic [8:0] junk;
		void'($urandom(94345));
		strap = 3'($urandom);
		dev_w = I2C_BASE_ADDR + {4'h0, strap, 1'b0};
		do_reset();
		i2c_op(1'b0, 16'($urandom) & 16'hFFFE, 1);
		chk("mode", {mode_i2c, mode_spi}, 2'b10);
		i2c_op(1'b0, 16'($urandom) & 16'hFFFE, 3);
		i2c_op(1'b1, 16'($urandom) & 16'hFFFE, 1);
		i2c_op(1'b1, 16'hFFFC, 3);
		for (int k = 1; k < 8; k++) begin
			c = strap + 3'(k);
			i2c_refuse(I2C_BASE_ADDR + {4'h0, c, 1'b0});
		end
		i2c_refuse(dev_w | 8'h01);
		host.start();
		host.tx(dev_w, junk[0]);
		host.tx(8'h00, junk[0]);
		host.tx(8'h10, junk[0]);
		host.tx(8'hAB, junk[0]);
		host.xfer(9'h1FF, 4, junk);
		host.start();
		host.tx(dev_w, junk[0]);
		chk("abort ack", junk[0], 1'b0);
		host.stop();
		drain();
		spi_op(1'b0, 15'h0040, 2, 1'b0);
		chk("sda drive", sda_out, 1'b0);
		strap = 3'($urandom);
		dev_w = I2C_BASE_ADDR + {4'h0, strap, 1'b0};
		do_reset();
		spi_op(1'b0, 15'($urandom) & 15'h3FFE, 1, 1'b1);
		chk("mode", {mode_i2c, mode_spi}, 2'b01);
		spi_op(1'b0, 15'($urandom) & 15'h3FFE, 3, 1'b1);
		spi_op(1'b1, 15'($urandom) & 15'h3FFE, 1, 1'b1);
		spi_op(1'b1, 15'($urandom) & 15'h3FFE, 3, 1'b1);
		i2c_refuse(dev_w);
		end_of_test();
	end

	initial begin
		#300us;
		n_errors++;
		end_of_test();
	end
endmodule

`default_nettype wire
